// file: logic/front_end_consts.svh
// Purpose: named constants for the odometer pin front end
// Assumes: included by bare name
// Notes:   definitions only
`ifndef FRONT_END_CONSTS_SVH
`define FRONT_END_CONSTS_SVH
// synchroniser slots, one per pin input
`define IN_SPEED        0
`define IN_DIR          1
`define IN_STRAP        2
`define IN_SDA          3
`define IN_SCL          4
`define IN_RXD          5
`define IN_COUNT        6
// idle levels: strap and serial pins high, odometry pins low
`define IN_RESET_LEVELS 6'h3c
`define SETTLE_CNT_LAST 2'h3
`define STRAP_SPI_LEVEL 1'h0
`define RTC_CLR_RESET   1'h1
`define IDLE_HIGH       1'h1
`define IDLE_LOW        1'h0
`endif

// file: logic/front_end_pkg.sv
// Purpose: shared types of the odometer pin front end
// Assumes: nothing
// Notes:   one-hot codes written out
package front_end_pkg;
    typedef enum logic [1:0] {
        STRAP_SETTLE = 2'b01,
        STRAP_HELD   = 2'b10
    } strap_state_e;
endpackage : front_end_pkg

// file: logic/odometer_pin_front_end.sv
// Purpose: pin front end for speed pulse, direction, strap, amp, grid pulse
// Assumes: core_clk 50 MHz, resetn async active low, clk_en freezes state
// Notes:   every pin input passes three flops before use
//
// Notes on behaviour
// - external reset also clears real-time clock
// - default: count speed pulse rising edges only
// - option counts both edges; equal mark/space
// - pulse rate linear in speed, one scale
// - speed pin reusable as message time mark
// - auto direction polarity at minimum speed
// - manual polarity setting overrides automatic one
// - host-supplied direction ignores direction pin
// - strap open: uart+i2c; low: spi only
// - shared pins routed by sampled strap
// - power save drives amplifier enable output
// - grid pulse train aligned to time grid
// - grid pulse disabled until configured
`include "front_end_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module odometer_pin_front_end #(
    parameter int TICK_W   = 16,
    parameter int STAMP_W  = 32,
    parameter int PERIOD_W = 16
) (
    input  wire logic                core_clk,
    input  wire logic                resetn,
    input  wire logic                clk_en,
    input  wire logic                speed_pulse_in,
    input  wire logic                direction_in,
    input  wire logic                strap_sel_in,
    input  wire logic                cfg_both_edges,
    input  wire logic                cfg_ext_int_mode,
    input  wire logic                cfg_dir_manual,
    input  wire logic                cfg_dir_polarity,
    input  wire logic                cfg_dir_from_host,
    input  wire logic                host_dir_forward,
    input  wire logic                min_speed_reached,
    input  wire logic                motion_forward_ref,
    input  wire logic                power_save_mode,
    input  wire logic                amp_request,
    input  wire logic                grid_epoch_tick,
    input  wire logic                second_pulse_config_set,
    input  wire logic                cfg_pulse_enable,
    input  wire logic [PERIOD_W-1:0] cfg_pulse_period,
    input  wire logic [PERIOD_W-1:0] cfg_pulse_width,
    input  wire logic                i2c_sda_drive_low,
    input  wire logic                i2c_scl_drive_low,
    input  wire logic                uart_txd,
    input  wire logic                spi_miso,
    input  wire logic                spi_miso_oe,
    input  wire logic                sda_cs_in,
    output logic                     sda_cs_out,
    output logic                     sda_cs_oe,
    input  wire logic                scl_sck_in,
    output logic                     scl_sck_out,
    output logic                     scl_sck_oe,
    output logic                     txd_miso_out,
    output logic                     txd_miso_oe,
    input  wire logic                rxd_mosi_in,
    output logic                     rtc_clear,
    output logic [TICK_W-1:0]        tick_count,
    output logic                     tick_seen,
    output logic                     external_interrupt_one,
    output logic [STAMP_W-1:0]       mark_stamp,
    output logic                     forward,
    output logic                     direction_valid,
    output logic                     polarity_learned,
    output logic                     spi_enable,
    output logic                     serial_enable,
    output logic                     i2c_sda_in,
    output logic                     i2c_scl_in,
    output logic                     uart_rxd,
    output logic                     spi_select_low,
    output logic                     spi_serial_clock,
    output logic                     spi_mosi,
    output logic                     amp_enable_out,
    output logic                     grid_pulse_out,
    output logic                     grid_pulse_oe
);
////////////////////////////////////////////////////////////////////////////////
// input synchronisers; a level counts once stages two and three agree
    logic [`IN_COUNT-1:0] pin_raw;
    logic [`IN_COUNT-1:0] lvl_q;
    logic [`IN_COUNT-1:0] lvl_d;
    assign pin_raw = {rxd_mosi_in, scl_sck_in, sda_cs_in,
                      strap_sel_in, direction_in, speed_pulse_in};
    for (genvar i = 0; i < `IN_COUNT; i++) begin : g_sync
        logic s1_q, s2_q, s3_q;
        always_comb begin
            lvl_d[i] = (s2_q == s3_q) ? s3_q : lvl_q[i];
        end
        always_ff @(posedge core_clk or negedge resetn) begin
            if (!resetn) begin
                s1_q     <= 1'(`IN_RESET_LEVELS >> i);
                s2_q     <= 1'(`IN_RESET_LEVELS >> i);
                s3_q     <= 1'(`IN_RESET_LEVELS >> i);
                lvl_q[i] <= 1'(`IN_RESET_LEVELS >> i);
            end else if (clk_en) begin
                s1_q     <= pin_raw[i];
                s2_q     <= s1_q;
                s3_q     <= s2_q;
                lvl_q[i] <= lvl_d[i];
            end
        end
    end
////////////////////////////////////////////////////////////////////////////////
// speed pulse counting and time mark
    logic               spd_rise, spd_fall;
    logic [TICK_W-1:0]  tick_q, tick_d;
    logic               seen_q, seen_d, mark_q, mark_d, rtc_q;
    logic [STAMP_W-1:0] time_q, time_d, stamp_q, stamp_d;
    assign spd_rise = lvl_d[`IN_SPEED] & ~lvl_q[`IN_SPEED];
    assign spd_fall = ~lvl_d[`IN_SPEED] & lvl_q[`IN_SPEED];
    always_comb begin
        tick_d  = tick_q;
        seen_d  = 1'b0;
        mark_d  = 1'b0;
        stamp_d = stamp_q;
        time_d  = time_q + STAMP_W'(1);
        if (cfg_ext_int_mode) begin
            if (spd_rise) begin
                mark_d  = 1'b1;
                stamp_d = time_q;
            end
        end else if (spd_rise || (cfg_both_edges && spd_fall)) begin
            // one count per edge keeps distance linear in ticks
            tick_d = tick_q + TICK_W'(1);
            seen_d = 1'b1;
        end
    end
    // reset clears the rest of the block and sets the real-time clock request
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            tick_q  <= '0;
            seen_q  <= 1'b0;
            mark_q  <= 1'b0;
            stamp_q <= '0;
            time_q  <= '0;
            rtc_q   <= `RTC_CLR_RESET;
        end else if (clk_en) begin
            tick_q  <= tick_d;
            seen_q  <= seen_d;
            mark_q  <= mark_d;
            stamp_q <= stamp_d;
            time_q  <= time_d;
            rtc_q   <= 1'b0;
        end
    end
////////////////////////////////////////////////////////////////////////////////
// direction polarity
    logic pol_q, pol_d, learned_q, learned_d, fwd_q, fwd_d, valid_q, valid_d;
    always_comb begin
        pol_d     = pol_q;
        learned_d = learned_q;
        if (!learned_q && min_speed_reached) begin
            pol_d     = lvl_q[`IN_DIR] ^ motion_forward_ref;
            learned_d = 1'b1;
        end
        if (cfg_dir_from_host) begin
            fwd_d   = host_dir_forward;
            valid_d = 1'b1;
        end else if (cfg_dir_manual) begin
            fwd_d   = lvl_q[`IN_DIR] ^ cfg_dir_polarity;
            valid_d = 1'b1;
        end else begin
            fwd_d   = lvl_q[`IN_DIR] ^ pol_q;
            valid_d = learned_q;
        end
    end
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            pol_q     <= 1'b0;
            learned_q <= 1'b0;
            fwd_q     <= 1'b0;
            valid_q   <= 1'b0;
        end else if (clk_en) begin
            pol_q     <= pol_d;
            learned_q <= learned_d;
            fwd_q     <= fwd_d;
            valid_q   <= valid_d;
        end
    end
////////////////////////////////////////////////////////////////////////////////
// strap capture and shared pin routing
// limitation: spi clock is seen through five flops, so it must run slow
    front_end_pkg::strap_state_e st_q, st_d;
    logic [1:0] settle_q, settle_d;
    logic       spi_q, spi_d, ser_q, ser_d;
    logic [5:0] pin_q, pin_d;   // txd out/oe, scl out/oe, sda out/oe
    logic [5:0] eng_q, eng_d;   // sda, scl, rxd, cs_n, sck, mosi
    always_comb begin
        st_d     = st_q;
        settle_d = settle_q;
        spi_d    = spi_q;
        ser_d    = ser_q;
        case (st_q)
            front_end_pkg::STRAP_SETTLE: begin
                settle_d = settle_q + 2'h1;
                if (settle_q == `SETTLE_CNT_LAST) begin
                    // next level: the registered one still shows reset idle
                    spi_d = (lvl_d[`IN_STRAP] == `STRAP_SPI_LEVEL);
                    ser_d = ~spi_d;
                    st_d  = front_end_pkg::STRAP_HELD;
                end
            end
            front_end_pkg::STRAP_HELD: st_d = front_end_pkg::STRAP_HELD;
            default: st_d = front_end_pkg::STRAP_SETTLE;
        endcase
        pin_d = '0;
        eng_d = {`IDLE_HIGH, `IDLE_HIGH, `IDLE_HIGH,
                 `IDLE_HIGH, `IDLE_LOW, `IDLE_LOW};
        if (spi_q) begin
            pin_d = {spi_miso, spi_miso_oe, 4'h0};
            eng_d = {`IDLE_HIGH, `IDLE_HIGH, `IDLE_HIGH, lvl_q[`IN_SDA],
                     lvl_q[`IN_SCL], lvl_q[`IN_RXD]};
        end else if (ser_q) begin
            pin_d = {uart_txd, 1'b1, 1'b0, i2c_scl_drive_low,
                     1'b0, i2c_sda_drive_low};
            eng_d = {lvl_q[`IN_SDA], lvl_q[`IN_SCL], lvl_q[`IN_RXD],
                     `IDLE_HIGH, `IDLE_LOW, `IDLE_LOW};
        end
    end
    // pins stay released until the strap is taken
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            st_q     <= front_end_pkg::STRAP_SETTLE;
            settle_q <= '0;
            spi_q    <= 1'b0;
            ser_q    <= 1'b0;
            pin_q    <= '0;
            eng_q    <= {`IDLE_HIGH, `IDLE_HIGH, `IDLE_HIGH,
                         `IDLE_HIGH, `IDLE_LOW, `IDLE_LOW};
        end else if (clk_en) begin
            st_q     <= st_d;
            settle_q <= settle_d;
            spi_q    <= spi_d;
            ser_q    <= ser_d;
            pin_q    <= pin_d;
            eng_q    <= eng_d;
        end
    end
////////////////////////////////////////////////////////////////////////////////
// amplifier enable and grid pulse
    logic                amp_q, amp_d, gen_q, gen_d, gp_q, gp_d, last;
    logic [PERIOD_W-1:0] epoch_q, epoch_d, wcnt_q, wcnt_d;
    assign last = (epoch_q + PERIOD_W'(1)) >= cfg_pulse_period;
    always_comb begin
        amp_d   = power_save_mode ? amp_request : 1'b1;
        gen_d   = second_pulse_config_set ? cfg_pulse_enable : gen_q;
        epoch_d = epoch_q;
        wcnt_d  = (wcnt_q != '0) ? wcnt_q - PERIOD_W'(1) : wcnt_q;
        if (!gen_q) begin
            epoch_d = '0;
            wcnt_d  = '0;
        end else if (grid_epoch_tick) begin
            epoch_d = last ? '0 : epoch_q + PERIOD_W'(1);
            if (last) begin
                wcnt_d = cfg_pulse_width;
            end
        end
        gp_d = gen_q && (wcnt_d != '0);
    end
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            amp_q   <= 1'b1;
            gen_q   <= 1'b0;
            gp_q    <= 1'b0;
            epoch_q <= '0;
            wcnt_q  <= '0;
        end else if (clk_en) begin
            amp_q   <= amp_d;
            gen_q   <= gen_d;
            gp_q    <= gp_d;
            epoch_q <= epoch_d;
            wcnt_q  <= wcnt_d;
        end
    end
////////////////////////////////////////////////////////////////////////////////
    assign rtc_clear              = rtc_q;
    assign tick_count             = tick_q;
    assign tick_seen              = seen_q;
    assign external_interrupt_one = mark_q;
    assign mark_stamp             = stamp_q;
    assign forward                = fwd_q;
    assign direction_valid        = valid_q;
    assign polarity_learned       = learned_q;
    assign spi_enable             = spi_q;
    assign serial_enable          = ser_q;
    assign {txd_miso_out, txd_miso_oe, scl_sck_out, scl_sck_oe,
            sda_cs_out, sda_cs_oe} = pin_q;
    assign {i2c_sda_in, i2c_scl_in, uart_rxd, spi_select_low,
            spi_serial_clock, spi_mosi} = eng_q;
    assign amp_enable_out         = amp_q;
    assign grid_pulse_out         = gp_q;
    assign grid_pulse_oe          = gen_q;
////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    sequence s_rise_counted;
        clk_en && spd_rise && !cfg_ext_int_mode;
    endsequence
    a_rise_counts: assert property (s_rise_counted |=>
        tick_count == $past(tick_count) + TICK_W'(1) && tick_seen)
        else $error("rising edge not counted");
    a_fall_counts: assert property (clk_en && spd_fall
        && cfg_both_edges && !cfg_ext_int_mode |=>
        tick_count == $past(tick_count) + TICK_W'(1))
        else $error("falling edge not counted in both-edge mode");
    a_fall_ignored: assert property (clk_en && spd_fall
        && !cfg_both_edges |=> $stable(tick_count))
        else $error("falling edge counted in rising mode");
    a_time_mark: assert property (clk_en && spd_rise
        && cfg_ext_int_mode |=> external_interrupt_one && $stable(tick_count))
        else $error("time mark missing or tick counted");
    a_host_dir: assert property (clk_en && cfg_dir_from_host |=>
        forward == $past(host_dir_forward))
        else $error("host direction not followed");
    a_manual_pol: assert property (clk_en && !cfg_dir_from_host
        && cfg_dir_manual |=>
        forward == ($past(lvl_q[`IN_DIR]) ^ $past(cfg_dir_polarity)))
        else $error("manual polarity not applied");
    a_iface_excl: assert property (!(spi_enable && serial_enable))
        else $error("spi and serial ports enabled together");
    a_strap_hold: assert property (st_q == front_end_pkg::STRAP_HELD
        |=> $stable(spi_enable) && $stable(serial_enable))
        else $error("interface routing changed after capture");
    a_spi_pins_in: assert property (spi_enable ##1 spi_enable |->
        !sda_cs_oe && !scl_sck_oe)
        else $error("spi input pins driven");
    a_pulse_gated: assert property ($rose(grid_pulse_oe) |->
        $past(clk_en && second_pulse_config_set && cfg_pulse_enable))
        else $error("grid pulse enabled without configuration");
    a_rtc_clear: assert property (rtc_clear && clk_en |=> !rtc_clear)
        else $error("rtc clear request stuck");
    a_amp_follow: assert property (clk_en && power_save_mode |=>
        amp_enable_out == $past(amp_request))
        else $error("amplifier enable not following request");
endmodule : odometer_pin_front_end
`default_nettype wire

// file: sim/odo_partner.sv
// Purpose: vehicle side of the pin front end: speed sensor, direction, strap
// Assumes: driven from the falling edge of core_clk
// Notes:   pin stays low between bursts, so no stray edge at start-up
`timescale 1ns/1ns
`default_nettype none
module odo_partner (
    input  wire logic core_clk,
    output logic      speed_pulse_in,
    output logic      direction_in,
    output logic      strap_sel_in
);
    ////////////////////////////////////////////////////////////////////////
    // service boot pin left unconnected; grid pin never loaded low
    initial begin
        speed_pulse_in = 1'h0;
        direction_in   = 1'h0;
        strap_sel_in   = 1'h1;
    end
    // equal mark and space of w cycles; larger w stands for lower speed
    task automatic emit(input int n, input int w);
        for (int i = 0; i < n; i++) begin
            repeat (w) @(negedge core_clk);
            speed_pulse_in = 1'h1;
            repeat (w) @(negedge core_clk);
            speed_pulse_in = 1'h0;
        end
    endtask : emit
    task automatic set_dir(input logic v);
        direction_in = v;
    endtask : set_dir
    task automatic set_strap(input logic v);
        strap_sel_in = v;
    endtask : set_strap
endmodule : odo_partner
`default_nettype wire

// file: sim/tb.sv
// Purpose: self-checking bench for the odometer pin front end
// Assumes: inputs driven and outputs read on the falling edge
// Notes:   clk_en held high; freezing is not exercised
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic        core_clk, resetn, clk_en, cfg_both_edges, cfg_ext_int_mode;
    logic        cfg_dir_manual, cfg_dir_polarity, cfg_dir_from_host;
    logic        host_dir_forward, min_speed_reached, motion_forward_ref;
    logic        power_save_mode, amp_request, grid_epoch_tick;
    logic        second_pulse_config_set, cfg_pulse_enable;
    logic [15:0] cfg_pulse_period, cfg_pulse_width, tick_count, exp_cnt;
    logic        i2c_sda_drive_low, i2c_scl_drive_low, uart_txd, spi_miso;
    logic        spi_miso_oe, sda_cs_out, sda_cs_oe, scl_sck_out, scl_sck_oe;
    logic        txd_miso_out, txd_miso_oe, rxd_mosi_in, rtc_clear, tick_seen;
    logic        external_interrupt_one, forward, direction_valid;
    logic        polarity_learned, spi_enable, serial_enable, i2c_sda_in;
    logic        i2c_scl_in, uart_rxd, spi_select_low, spi_serial_clock;
    logic        spi_mosi, amp_enable_out, grid_pulse_out, grid_pulse_oe;
    logic        speed_pulse_in, direction_in, strap_sel_in, host_sda, host_scl;
    logic        d;
    logic [31:0] mark_stamp;
    // open-drain style pins: pulled high by the host side when released
    wire         sda_cs_in = sda_cs_oe ? sda_cs_out : host_sda;
    wire         scl_sck_in = scl_sck_oe ? scl_sck_out : host_scl;
    int          bad_count, cmp_count, ext_cnt, hi_cnt, n, w;
    integer      seed;
    ////////////////////////////////////////////////////////////////////////
    odometer_pin_front_end uut (.*);
    odo_partner part (.core_clk, .speed_pulse_in, .direction_in, .strap_sel_in);
    initial begin
        core_clk = 1'h0;
        forever #10 core_clk = ~core_clk;
    end
    // sampled mid-cycle, away from the edge that launches the pulse
    always @(negedge core_clk) begin
        if (external_interrupt_one === 1'h1) ext_cnt++;
        if (grid_pulse_out === 1'h1) hi_cnt++;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic check_bit(input string nm, input logic e, input logic g);
        cmp_count++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : check_bit
    task automatic check_vec(input string nm, input logic [15:0] e,
                             input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : check_vec
    task automatic complete_run;
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : complete_run
    task automatic wait_n(input int k);
        repeat (k) @(negedge core_clk);
    endtask : wait_n
    // reset only as recovery at the start of each mode, never as power off
    task automatic do_reset(input logic s);
        resetn = 1'h0;
        part.set_strap(s);
        wait_n(16);
        check_bit("rtc_clear", 1'h1, rtc_clear);
        check_vec("tick_count", 16'h0, tick_count);
        check_bit("sda_cs_oe", 1'h0, sda_cs_oe);
        check_bit("amp_enable_out", 1'h1, amp_enable_out);
        check_bit("grid_pulse_oe", 1'h0, grid_pulse_oe);
        resetn = 1'h1;
        wait_n(2);
        check_bit("rtc_clear", 1'h0, rtc_clear);
        wait_n(6);
        part.set_strap(~s);
        wait_n(8);
        check_bit("spi_enable", ~s, spi_enable);
        check_bit("serial_enable", s, serial_enable);
        exp_cnt = 16'h0;
    endtask : do_reset
    task automatic pulses(input logic b, input logic x);
        {cfg_both_edges, cfg_ext_int_mode} = {b, x};
        ext_cnt = 0;
        n = 1 + ($unsigned($random(seed)) % 8);
        w = 4 + ($unsigned($random(seed)) % 6);
        part.emit(n, w);
        wait_n(8);
        if (!x) exp_cnt = exp_cnt + 16'(b ? 2 * n : n);
        check_vec("tick_count", exp_cnt, tick_count);
        check_vec("time_marks", 16'(x ? n : 0), 16'(ext_cnt));
    endtask : pulses
    task automatic tick_epoch;
        grid_epoch_tick = 1'h1;
        wait_n(1);
        grid_epoch_tick = 1'h0;
        wait_n(9);
    endtask : tick_epoch
    ////////////////////////////////////////////////////////////////////////
    initial begin
        {resetn, clk_en, cfg_both_edges, cfg_ext_int_mode} = 4'h4;
        {cfg_dir_manual, cfg_dir_polarity, cfg_dir_from_host} = 3'h0;
        {host_dir_forward, min_speed_reached, motion_forward_ref} = 3'h0;
        {power_save_mode, amp_request, grid_epoch_tick} = 3'h0;
        {second_pulse_config_set, cfg_pulse_enable} = 2'h0;
        {cfg_pulse_period, cfg_pulse_width} = 32'h0;
        {i2c_sda_drive_low, i2c_scl_drive_low, uart_txd} = 3'h1;
        {spi_miso, spi_miso_oe, rxd_mosi_in, host_sda, host_scl} = 5'h7;
        {bad_count, cmp_count, ext_cnt, hi_cnt} = 128'h0;
        seed = 32'he7b0ff1e;
        wait_n(1);
        do_reset(1'h0);
        for (int i = 0; i < 4; i++) begin
            {host_sda, host_scl, rxd_mosi_in, spi_miso, spi_miso_oe} =
                5'($random(seed));
            wait_n(6);
            check_bit("spi_select_low", host_sda, spi_select_low);
            check_bit("spi_serial_clock", host_scl, spi_serial_clock);
            check_bit("spi_mosi", rxd_mosi_in, spi_mosi);
            check_bit("txd_miso_oe", spi_miso_oe, txd_miso_oe);
            if (spi_miso_oe) check_bit("txd_miso_out", spi_miso, txd_miso_out);
            check_bit("uart_rxd", 1'h1, uart_rxd);
        end
        pulses(1'h0, 1'h0);
        pulses(1'h1, 1'h0);
        pulses(1'h0, 1'h1);
        pulses(1'h0, 1'h0);
        for (int i = 0; i < 6; i++) begin
            {power_save_mode, amp_request} = 2'($random(seed));
            wait_n(2);
            d = power_save_mode ? amp_request : 1'h1;
            check_bit("amp_enable_out", d, amp_enable_out);
        end
        hi_cnt = 0;
        repeat (3) tick_epoch();
        check_vec("grid_high", 16'h0, 16'(hi_cnt));
        check_bit("grid_pulse_oe", 1'h0, grid_pulse_oe);
        w = 1 + ($unsigned($random(seed)) % 6);
        {cfg_pulse_enable, cfg_pulse_period, cfg_pulse_width} =
            {1'h1, 16'h2, 16'(w)};
        second_pulse_config_set = 1'h1;
        wait_n(1);
        second_pulse_config_set = 1'h0;
        wait_n(2);
        check_bit("grid_pulse_oe", 1'h1, grid_pulse_oe);
        hi_cnt = 0;
        repeat (4) tick_epoch();
        check_vec("grid_high", 16'(2 * w), 16'(hi_cnt));
        // released open-drain lines float to the host pull-ups
        {host_sda, host_scl} = 2'h3;
        do_reset(1'h1);
        for (int i = 0; i < 4; i++) begin
            {i2c_sda_drive_low, uart_txd, rxd_mosi_in} = 3'($random(seed));
            wait_n(6);
            check_bit("sda_cs_oe", i2c_sda_drive_low, sda_cs_oe);
            check_bit("sda_cs_out", 1'h0, sda_cs_out);
            check_bit("i2c_sda_in", ~i2c_sda_drive_low, i2c_sda_in);
            check_bit("txd_miso_out", uart_txd, txd_miso_out);
            check_bit("uart_rxd", rxd_mosi_in, uart_rxd);
            check_bit("spi_select_low", 1'h1, spi_select_low);
        end
        check_bit("direction_valid", 1'h0, direction_valid);
        part.set_dir(1'h1);
        wait_n(6);
        min_speed_reached = 1'h1;
        wait_n(1);
        min_speed_reached = 1'h0;
        wait_n(4);
        check_bit("polarity_learned", 1'h1, polarity_learned);
        check_bit("direction_valid", 1'h1, direction_valid);
        check_bit("forward", 1'h0, forward);
        // a second learning pulse with the other reference must be refused
        {motion_forward_ref, min_speed_reached} = 2'h3;
        wait_n(1);
        min_speed_reached = 1'h0;
        part.set_dir(1'h0);
        wait_n(6);
        check_bit("forward", 1'h1, forward);
        cfg_dir_manual = 1'h1;
        for (int i = 0; i < 8; i++) begin
            {cfg_dir_from_host, cfg_dir_polarity, host_dir_forward, d} =
                {i[2], 3'($random(seed))};
            part.set_dir(d);
            wait_n(6);
            if (i[2]) check_bit("forward", host_dir_forward, forward);
            else check_bit("forward", d ^ cfg_dir_polarity, forward);
        end
        complete_run();
    end
    // the whole run is under a thousand cycles; this allows ample margin
    initial begin
        #2000000;
        bad_count++;
        complete_run();
    end
endmodule : tb
`default_nettype wire
